// File: core/pdsc_pkg.sv
/*
 * pdsc_pkg: constants for the power-down system control block.
 * assumes: compiled before pdsc_top; no other dependencies.
 */
package pdsc_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] PDSC_IDX_CONTROL = 16'hd002;
    localparam logic [15:0] PDSC_IDX_STATUS  = 16'hd003;

    // control field positions
    localparam int PDSC_BIT_STOP      = 0;
    localparam int PDSC_BIT_IDLE      = 1;
    localparam int PDSC_DIV_LSB       = 3;
    localparam int PDSC_DIV_MSB       = 5;
    localparam int PDSC_BIT_BT_STOP   = 6;
    localparam int PDSC_BIT_UART_STOP = 7;
    localparam int PDSC_BIT_GIE       = 8;

    // writable bits and value after reset
    localparam logic [15:0] PDSC_CONTROL_MASK  = 16'h01fb;
    localparam logic [15:0] PDSC_CONTROL_RESET = 16'h0000;

    // divide codes
    localparam logic [2:0] PDSC_DIV_16   = 3'h0;
    localparam logic [2:0] PDSC_DIV_8    = 3'h1;
    localparam logic [2:0] PDSC_DIV_2    = 3'h2;
    localparam logic [2:0] PDSC_DIV_1    = 3'h3;
    localparam logic [2:0] PDSC_DIV_1024 = 3'h4;

    // terminal counts of the divider (ratio minus one)
    localparam logic [9:0] PDSC_TC_16   = 10'h00f;
    localparam logic [9:0] PDSC_TC_8    = 10'h007;
    localparam logic [9:0] PDSC_TC_2    = 10'h001;
    localparam logic [9:0] PDSC_TC_1    = 10'h000;
    localparam logic [9:0] PDSC_TC_1024 = 10'h3ff;

    // flash start-up after idle, in master clock cycles (clk is mclk);
    // kept as a terminal count, since the counter starts from zero
    localparam int          PDSC_FLASH_START_MCLK = 32;
    localparam logic [5:0]  PDSC_FLASH_START_TC   =
        6'(PDSC_FLASH_START_MCLK - 1);

    // power states
    typedef enum logic [3:0] {
        PDSC_RUN   = 4'h1,
        PDSC_STOP  = 4'h2,
        PDSC_IDLE  = 4'h4,
        PDSC_WAKE  = 4'h8
    } pdsc_state_t;

endpackage : pdsc_pkg

// File: core/pdsc_top.sv
/*
 * pdsc_top: power-down modes, wake-up, flash start-up delay, external
 * clock divider, peripheral stop bits and global interrupt gate, with an
 * avalon-mm slave for the control and status registers.
 * assumes: clk is the master clock; irq_pending comes already masked by
 * the interrupt controller; external lines and ext clock are async pins.
 */
`timescale 1ns/1ps
`default_nettype none
module pdsc_top
    import pdsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave, word addressed
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // pins and interrupt controller
    input  wire logic [2:0]  external_interrupt_lines,
    input  wire logic        external_clock_input,
    input  wire logic        irq_pending,
    // system outputs
    output logic             irq_to_cpu,
    output logic             cpu_halt,
    output logic             flash_stop,
    output logic             all_logic_stop,
    output logic             basic_timer_stop,
    output logic             uart_stop,
    output logic             ext_clock_tick
);
    import pdsc_pkg::*;

    logic [15:0] system_control_reg;
    pdsc_state_t state;
    pdsc_state_t next_state;
    logic        ack;
    logic        wr_ctrl;
    logic        stop_wake;
    logic        idle_wake;
    logic [5:0]  flash_cnt;
    logic [2:0]  external_interrupt_lines_s1;
    logic [2:0]  external_interrupt_lines_s2;
    logic [2:0]  external_interrupt_lines_s3;
    logic [2:0]  external_interrupt_lines_level;
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_s3;
    logic        ck_level;
    logic        ck_rise;
    logic [9:0]  div_cnt;
    logic [9:0]  div_tc;
    logic        div_reserved;
    logic [2:0]  clock_divide_select;

    assign clock_divide_select = system_control_reg[PDSC_DIV_MSB:PDSC_DIV_LSB];

    // bus handshake: every access answers one cycle after it is presented
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_ctrl = avs_write & ack & (avs_address == PDSC_IDX_CONTROL);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack <= 1'b0;
        else
            ack <= (avs_read | avs_write) & ~ack;
    end

    // read data loaded as ack rises; unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !ack)
        begin
            if (avs_address == PDSC_IDX_CONTROL)
                avs_readdata <= {16'h0000, system_control_reg};
            else if (avs_address == PDSC_IDX_STATUS)
                avs_readdata <= {26'h0, div_reserved, 1'b0, state};
            else
                avs_readdata <= 32'h0000_0000;
        end
    end

    // external lines: three flops, level accepted once stages 2 and 3 agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            external_interrupt_lines_s1    <= 3'h0;
            external_interrupt_lines_s2    <= 3'h0;
            external_interrupt_lines_s3    <= 3'h0;
            external_interrupt_lines_level <= 3'h0;
        end
        else
        begin
            external_interrupt_lines_s1 <= external_interrupt_lines;
            external_interrupt_lines_s2 <= external_interrupt_lines_s1;
            external_interrupt_lines_s3 <= external_interrupt_lines_s2;
            for (int i = 0; i < 3; i++)
                if (external_interrupt_lines_s2[i] == external_interrupt_lines_s3[i])
                    external_interrupt_lines_level[i] <= external_interrupt_lines_s3[i];
        end
    end

    // wake causes; the global enable refuses idle wake like any irq
    assign stop_wake = |external_interrupt_lines_level;
    assign idle_wake = irq_pending & system_control_reg[PDSC_BIT_GIE];
    assign irq_to_cpu = irq_pending & system_control_reg[PDSC_BIT_GIE]
                        & (state == PDSC_RUN);

    // power state sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            PDSC_RUN:
                if (wr_ctrl && avs_writedata[PDSC_BIT_STOP])
                    next_state = PDSC_STOP;
                else if (wr_ctrl && avs_writedata[PDSC_BIT_IDLE])
                    next_state = PDSC_IDLE;
            PDSC_STOP:
                if (stop_wake)
                    next_state = PDSC_RUN;
            PDSC_IDLE:
                if (idle_wake)
                    next_state = PDSC_WAKE;
            PDSC_WAKE:
                if (flash_cnt == PDSC_FLASH_START_TC)
                    next_state = PDSC_RUN;
            default:
                next_state = PDSC_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= PDSC_RUN;
        else
            state <= next_state;
    end

    // flash start-up counter, runs only in the wake state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flash_cnt <= 6'h00;
        else if (state == PDSC_WAKE)
            flash_cnt <= flash_cnt + 6'h01;
        else
            flash_cnt <= 6'h00;
    end

    // control register; the cpu is halted while a mode bit is set, so a
    // software write can never race the self-clear on wake-up
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            system_control_reg <= PDSC_CONTROL_RESET;
        else if (wr_ctrl && state == PDSC_RUN)
        begin
            system_control_reg <= avs_writedata[15:0] & PDSC_CONTROL_MASK;
            // stop wins when both mode bits are written together
            if (avs_writedata[PDSC_BIT_STOP])
                system_control_reg[PDSC_BIT_IDLE] <= 1'b0;
        end
        else if (state == PDSC_STOP && stop_wake)
            system_control_reg[PDSC_BIT_STOP] <= 1'b0;
        else if (state == PDSC_IDLE && idle_wake)
            system_control_reg[PDSC_BIT_IDLE] <= 1'b0;
    end

    // external clock: synchronised, rising edge from agreeing stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ck_s1    <= 1'b0;
            ck_s2    <= 1'b0;
            ck_s3    <= 1'b0;
            ck_level <= 1'b0;
        end
        else
        begin
            ck_s1 <= external_clock_input;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            if (ck_s2 == ck_s3)
                ck_level <= ck_s3;
        end
    end

    assign ck_rise = (ck_s2 == ck_s3) & ck_s3 & ~ck_level;

    // terminal count per divide code; reserved codes give no ticks
    always_comb
    begin
        div_tc       = PDSC_TC_1;
        div_reserved = 1'b0;
        case (clock_divide_select)
            PDSC_DIV_16:   div_tc = PDSC_TC_16;
            PDSC_DIV_8:    div_tc = PDSC_TC_8;
            PDSC_DIV_2:    div_tc = PDSC_TC_2;
            PDSC_DIV_1:    div_tc = PDSC_TC_1;
            PDSC_DIV_1024: div_tc = PDSC_TC_1024;
            default:       div_reserved = 1'b1;
        endcase
    end

    // divider frozen in stop mode, so its phase survives the stop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt        <= 10'h000;
            ext_clock_tick <= 1'b0;
        end
        else if (state == PDSC_STOP || div_reserved)
        begin
            ext_clock_tick <= 1'b0;
            if (div_reserved)
                div_cnt <= 10'h000;
        end
        else if (ck_rise && div_cnt >= div_tc)
        begin
            div_cnt        <= 10'h000;
            ext_clock_tick <= 1'b1;
        end
        else
        begin
            ext_clock_tick <= 1'b0;
            if (ck_rise)
                div_cnt <= div_cnt + 10'h001;
        end
    end

    // power and stop outputs, registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_halt         <= 1'b0;
            flash_stop       <= 1'b0;
            all_logic_stop   <= 1'b0;
            basic_timer_stop <= 1'b0;
            uart_stop        <= 1'b0;
        end
        else
        begin
            cpu_halt       <= (next_state != PDSC_RUN);
            flash_stop     <= (next_state == PDSC_STOP)
                              | (next_state == PDSC_IDLE);
            all_logic_stop <= (next_state == PDSC_STOP);
            // a stop request parks both peripherals as well
            basic_timer_stop <= system_control_reg[PDSC_BIT_BT_STOP]
                                | (next_state == PDSC_STOP);
            uart_stop      <= system_control_reg[PDSC_BIT_UART_STOP]
                              | (next_state == PDSC_STOP);
        end
    end

endmodule : pdsc_top
`default_nettype wire

// File: verif/pdsc_props.sv
/* pdsc_props: checker on the ports of pdsc_top, bound at the foot.
   assumes: one clock domain, word-addressed register bus. */
`timescale 1ns/1ps
`default_nettype none
module pdsc_props
    import pdsc_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // pins and system outputs
    input wire logic [2:0]  external_interrupt_lines,
    input wire logic        irq_pending,
    input wire logic        irq_to_cpu,
    input wire logic        cpu_halt,
    input wire logic        flash_stop,
    input wire logic        all_logic_stop,
    input wire logic        basic_timer_stop,
    input wire logic        uart_stop,
    input wire logic        ext_clock_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] wake_cnt;
    logic       ctl_wr;
    logic       gie_seen;
    // cycles halted with flash awake; 8 bits so a stuck wake shows
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            wake_cnt <= 8'h00;
        else if (cpu_halt && !flash_stop)
            wake_cnt <= wake_cnt + 8'h01;
        else
            wake_cnt <= 8'h00;
    // accepted control write; writes while halted are dropped
    assign ctl_wr = avs_write && !avs_waitrequest && !cpu_halt
        && avs_address == PDSC_IDX_CONTROL;
    // global enable as the last accepted control write left it
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            gie_seen <= 1'b0;
        else if (ctl_wr)
            gie_seen <= avs_writedata[8];
    sequence s_stopped; cpu_halt && flash_stop && all_logic_stop;
    endsequence
    sequence s_idled; cpu_halt && flash_stop && !all_logic_stop;
    endsequence
    sequence s_gated; s_idled ##0 !gie_seen;
    endsequence
    property p_all; all_logic_stop |-> s_stopped ##0 basic_timer_stop
        && uart_stop; endproperty
    a_all: assert property (p_all) else $error("stop not total");
    property p_stop; ctl_wr && avs_writedata[0] |-> ##[1:2] s_stopped;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop entry");
    property p_idle; ctl_wr && avs_writedata[1:0] == 2'h2 |-> ##[1:2]
        s_idled; endproperty
    a_idle: assert property (p_idle) else $error("no idle entry");
    property p_swake; all_logic_stop && |external_interrupt_lines |->
        ##[1:8] !cpu_halt; endproperty
    a_swake: assert property (p_swake) else $error("stop kept");
    property p_ihold; s_idled and !irq_pending |=> flash_stop; endproperty
    a_ihold: assert property (p_ihold) else $error("idle left");
    property p_flash; $fell(cpu_halt) && !$past(flash_stop) |->
        wake_cnt == 8'h20; endproperty
    a_flash: assert property (p_flash) else $error("start-up length");
    property p_gate; irq_to_cpu |-> irq_pending && gie_seen && !cpu_halt;
    endproperty
    a_gate: assert property (p_gate) else $error("irq passed");
    property p_take; irq_pending && gie_seen && !cpu_halt |-> irq_to_cpu;
    endproperty
    a_take: assert property (p_take) else $error("irq lost");
    property p_irefuse; s_gated |=> flash_stop; endproperty
    a_irefuse: assert property (p_irefuse) else $error("idle woke");
    property p_frz; all_logic_stop && $past(all_logic_stop) |->
        !ext_clock_tick; endproperty
    a_frz: assert property (p_frz) else $error("tick in stop");
endmodule : pdsc_props
bind pdsc_top pdsc_props pdsc_props_i (.clk, .rst_n, .avs_address,
    .avs_write, .avs_writedata, .avs_waitrequest, .external_interrupt_lines,
    .irq_pending, .irq_to_cpu, .cpu_halt, .flash_stop, .all_logic_stop,
    .basic_timer_stop, .uart_stop, .ext_clock_tick);
`default_nettype wire

// File: verif/pdsc_far_end.sv
/* pdsc_far_end: wake pins, interrupt controller and ext clock source.
   assumes: the bench changes its commands on rising edges. */
`timescale 1ns/1ps
`default_nettype none
module pdsc_far_end (
    // clock, reset and bench commands
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] line_req,
    input  wire logic       irq_req,
    input  wire logic       clk_run,
    // pins toward the block
    output logic [2:0]      external_interrupt_lines,
    output logic            irq_pending,
    output logic            external_clock_input
);
    logic [1:0] ph;
    // ext clock of four cycles; stands still when not running
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            ph <= 2'h0;
        else if (clk_run)
            ph <= ph + 2'h1;
    assign external_clock_input = ph[1];
    // wake sources are passed straight through from the bench commands
    assign external_interrupt_lines = line_req;
    assign irq_pending = irq_req;
endmodule : pdsc_far_end
`default_nettype wire

// File: verif/tb.sv
/* tb: bus-level test of pdsc_top facing the far-end model.
   assumes: checker bound in its own file; no random stimulus. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pdsc_pkg::*;
    localparam logic [15:0] CTL = PDSC_IDX_CONTROL;
    localparam logic [15:0] STA = PDSC_IDX_STATUS;
    logic        clk, rst_n, rd, wr, wq, irq, run, eck, irqp, ir;
    logic        hlt, fst, als, bts, uts, tck;
    logic [2:0]  lr, lines;
    logic [15:0] adr;
    logic [31:0] wd, rdat, q;
    int          errors, n_checks, n, k;
    int          ratio [5] = '{16, 8, 2, 1, 1024};
    pdsc_top pdsc_top_i (.clk, .rst_n, .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
        .avs_waitrequest(wq), .external_interrupt_lines(lines),
        .external_clock_input(eck), .irq_pending(irqp), .irq_to_cpu(ir),
        .cpu_halt(hlt), .flash_stop(fst), .all_logic_stop(als),
        .basic_timer_stop(bts), .uart_stop(uts), .ext_clock_tick(tck));
    pdsc_far_end pdsc_far_end_i (.clk, .rst_n, .line_req(lr),
        .irq_req(irq), .clk_run(run), .external_interrupt_lines(lines),
        .irq_pending(irqp), .external_clock_input(eck));
    // 100 MHz master clock
    always #5 clk = ~clk;
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic tmo;
        errors++;
        $display("MISMATCH %0t no answer", $time);
        finish_test();
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(negedge clk);
        repeat (8) if (wq !== 1'b0) @(negedge clk);
        if (wq !== 1'b0) tmo();
        @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // cycles to the next tick; 9000 means none came
    task automatic gap;
        n = 1;
        @(negedge clk);
        while (tck !== 1'b1 && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
    endtask : gap
    // watch a wake-up, counting halted cycles with flash running
    task automatic wake;
        n = 0;
        repeat (99)
        begin
            @(negedge clk);
            if (hlt === 1'b1 && fst === 1'b0)
                n++;
        end
        if (hlt !== 1'b0) tmo();
    endtask : wake
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {rd, wr, irq, run, lr, adr, wd, errors, n_checks} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, CTL, 0);
        chk(q, 0);
        run <= 1'b1;
        irq <= 1'b1;
        bus(1, CTL, 32'hffff_fffc);
        bus(1, 16'h0000, 32'h0000_01f8);
        bus(0, 16'h0000, 0);
        chk(q, 0);
        bus(0, CTL, 0);
        chk(q, 32'h0000_01f8);
        chk({bts, uts, ir}, 3'h7);
        gap;
        chk(n, 9000);
        bus(0, STA, 0);
        chk(q, 32'h0000_0021);
        bus(1, CTL, 0);
        repeat (2) @(negedge clk);
        chk({bts, uts, ir}, 3'h0);
        for (k = 0; k < 5; k++)
        begin
            bus(1, CTL, 32'(k) << 3);
            gap;
            gap;
            chk(n, 4 * ratio[k]);
        end
        // idle with global enable off must not wake; reset recovers
        bus(1, CTL, 32'h0000_0002);
        repeat (50) @(negedge clk);
        chk({als, hlt, fst}, 3'h3);
        bus(0, STA, 0);
        chk(q, 32'h0000_0004);
        // control writes while halted are dropped
        bus(1, CTL, 32'h0000_0100);
        bus(0, CTL, 0);
        chk(q, 32'h0000_0002);
        @(posedge clk);
        rst_n <= 1'b0;
        irq <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 0; k < 3; k++)
        begin
            bus(1, CTL, 32'h0000_0119);
            repeat (4) @(negedge clk);
            chk({als, hlt, fst}, 3'h7);
            @(posedge clk);
            lr <= 3'(1 << k);
            wake;
            chk(n, 0);
            @(posedge clk);
            lr <= 3'h0;
            bus(0, CTL, 0);
            chk(q, 32'h0000_0118);
        end
        bus(1, CTL, 32'h0000_0102);
        repeat (20) @(negedge clk);
        chk({als, hlt, fst}, 3'h3);
        @(posedge clk);
        irq <= 1'b1;
        wake;
        chk(n, 32);
        bus(0, CTL, 0);
        chk(q, 32'h0000_0100);
        finish_test();
    end
endmodule : tb
`default_nettype wire
